/* src/rps_sequencer.sv */
// rps_sequencer: reset pin handling, reset classification, start-up delay and clock source
// assumes i_rst is the power-on reset; the pin input may be asynchronous and passes a two-flop synchroniser on i_clock
`timescale 1ns/1ps
module rps_sequencer
    import rps_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // reset pin, open drain
    input wire logic i_pin_in,
    output logic o_pin_out,
    output logic o_pin_oe,
    // failure sources and halt mode
    input wire rps_fail_s i_fail,
    input wire logic i_halt_enter,
    input wire logic i_halt_exit,
    // manufacture-time options
    input wire logic i_options_present,
    input wire logic i_opt_short_startup,
    input wire logic [7:0] i_opt_synth_mult,
    // clock source
    input wire logic i_sw_select_pll,
    input wire logic i_pll_tick,
    output logic o_clk_sel_pll,
    output logic o_bus_tick,
    // status towards the core
    output logic o_sys_reset,
    output logic o_run,
    output rps_class_s o_class,
    output logic [7:0] o_synth_mult
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic sync1_ff;
    logic sync2_ff;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else if (i_ce) begin
            sync1_ff <= i_pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // option capture and clock source
    logic first_ff;
    logic opt_short_ff;
    logic sel_pll_ff;
    logic [1:0] div_ff;
    logic [7:0] synth_ff;
    logic nxt_first;
    logic nxt_opt_short;
    logic nxt_sel_pll;
    logic [1:0] nxt_div;
    logic [7:0] nxt_synth;
    logic bus_tick;

    always_comb begin
        nxt_first = 1'b0;
        nxt_opt_short = opt_short_ff;
        nxt_synth = synth_ff;
        nxt_sel_pll = sel_pll_ff;
        nxt_div = div_ff + 2'h1;
        if (first_ff) begin
            nxt_opt_short = i_options_present && i_opt_short_startup;
            nxt_synth = i_options_present ? i_opt_synth_mult : SYNTH_MULT_RESET;
        end
        if (i_sw_select_pll) begin
            nxt_sel_pll = 1'b1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            first_ff <= 1'b1;
            opt_short_ff <= 1'b0;
            synth_ff <= SYNTH_MULT_RESET;
            sel_pll_ff <= 1'b0;
            div_ff <= 2'h0;
        end else if (i_ce) begin
            first_ff <= nxt_first;
            opt_short_ff <= nxt_opt_short;
            synth_ff <= nxt_synth;
            sel_pll_ff <= nxt_sel_pll;
            div_ff <= nxt_div;
        end
    end

    // oscillator divided by four unless the loop output is the source
    assign bus_tick = sel_pll_ff ? i_pll_tick : (div_ff == OSC_DIV_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    rps_state_e state_ff;
    rps_state_e nxt_state;
    rps_class_s class_ff;
    rps_class_s nxt_class;
    logic [2:0] cls_cnt_ff;
    logic [2:0] nxt_cls_cnt;
    logic dly_load;
    logic [CNT_W-1:0] dly_count;
    logic dly_done;
    logic fail_any;

    assign fail_any = i_fail.fail_clock_monitor || i_fail.fail_watchdog;

    always_comb begin
        nxt_state = state_ff;
        nxt_class = class_ff;
        nxt_cls_cnt = cls_cnt_ff;
        dly_load = 1'b0;
        // the first load after power-on happens on the edge that captures the option
        dly_count = nxt_opt_short ? STARTUP_SHORT_CYC : STARTUP_LONG_CYC;
        case (state_ff)
            ST_STARTUP: begin
                if (first_ff) begin
                    dly_load = 1'b1;
                end else if (!sync2_ff) begin
                    nxt_state = ST_EXTERNAL;
                end else if (dly_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fail_any) begin
                    nxt_state = ST_DRIVE;
                    dly_load = 1'b1;
                    dly_count = DRIVE_LOW_CYC;
                end else if (!sync2_ff) begin
                    nxt_state = ST_EXTERNAL;
                    nxt_class = '{valid: 1'b1, internal: 1'b0};
                end else if (i_halt_enter) begin
                    nxt_state = ST_HALT;
                end
            end
            ST_DRIVE: begin
                if (dly_done) begin
                    nxt_state = ST_CLASSIFY;
                    nxt_cls_cnt = 3'h0;
                end
            end
            ST_CLASSIFY: begin
                if (sync2_ff && cls_cnt_ff < CLASSIFY_LIMIT) begin
                    nxt_state = ST_RUN;
                    nxt_class = '{valid: 1'b1, internal: 1'b1};
                end else if (cls_cnt_ff >= CLASSIFY_LIMIT) begin
                    nxt_state = ST_EXTERNAL;
                    nxt_class = '{valid: 1'b1, internal: 1'b0};
                end else if (bus_tick) begin
                    nxt_cls_cnt = cls_cnt_ff + 3'h1;
                end
            end
            ST_EXTERNAL: begin
                if (sync2_ff) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_HALT: begin
                if (!sync2_ff) begin
                    nxt_state = ST_EXTERNAL;
                end else if (i_halt_exit) begin
                    nxt_state = ST_STARTUP;
                    dly_load = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_STARTUP;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_STARTUP;
            class_ff <= '0;
            cls_cnt_ff <= 3'h0;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            class_ff <= nxt_class;
            cls_cnt_ff <= nxt_cls_cnt;
        end
    end

    rps_delay_counter u_delay (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_load(dly_load),
        .i_count(dly_count),
        .i_tick(bus_tick),
        .o_done(dly_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_pin_out = 1'b0;
    assign o_pin_oe = (state_ff == ST_DRIVE);
    assign o_sys_reset = (state_ff == ST_DRIVE) || (state_ff == ST_CLASSIFY) || (state_ff == ST_EXTERNAL);
    assign o_run = (state_ff == ST_RUN);
    assign o_class = class_ff;
    assign o_synth_mult = synth_ff;
    assign o_clk_sel_pll = sel_pll_ff;
    assign o_bus_tick = bus_tick;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_ext_hold;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && state_ff == ST_RUN && !fail_any && !sync2_ff) |=> o_sys_reset && !o_run;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("external low did not hold reset");

    property p_open_drain;
        @(posedge i_clock) disable iff (i_rst)
        o_pin_oe |-> (o_pin_out == 1'b0) && o_sys_reset;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven other than low");

    property p_fail_drive;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && state_ff == ST_RUN && fail_any) |=> o_pin_oe;
    endproperty
    a_fail_drive: assert property (p_fail_drive) else $error("failure did not pull pin low");

    property p_class_internal;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && state_ff == ST_CLASSIFY && sync2_ff && cls_cnt_ff < 3'h4) |=> o_class.valid && o_class.internal;
    endproperty
    a_class_internal: assert property (p_class_internal) else $error("fast rise not internal");

    property p_class_external;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && state_ff == ST_CLASSIFY && cls_cnt_ff == 3'h4) |=> o_class.valid && !o_class.internal;
    endproperty
    a_class_external: assert property (p_class_external) else $error("slow rise not external");

    property p_delay_load;
        @(posedge i_clock) disable iff (i_rst)
        (dly_load && state_ff != ST_RUN) |->
            dly_count == ((first_ff ? (i_options_present && i_opt_short_startup) : opt_short_ff)
                ? 12'h080 : 12'hFE0);
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("wrong start-up delay");

    property p_no_options;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && first_ff && !i_options_present) |=> o_synth_mult == 8'h01 && !opt_short_ff;
    endproperty
    a_no_options: assert property (p_no_options) else $error("no-option defaults wrong");

    property p_osc_source;
        @(posedge i_clock) disable iff (i_rst)
        first_ff |-> !o_clk_sel_pll;
    endproperty
    a_osc_source: assert property (p_osc_source) else $error("loop selected at reset");

    sequence s_osc_tick;
        i_ce && o_bus_tick && !o_clk_sel_pll && !i_sw_select_pll;
    endsequence
    sequence s_three_enabled;
        (i_ce && !i_sw_select_pll)[*3];
    endsequence
    property p_div_four;
        @(posedge i_clock) disable iff (i_rst)
        s_osc_tick ##1 s_three_enabled |->
            (!$past(o_bus_tick, 2) && !$past(o_bus_tick, 1) && !o_bus_tick) ##1 o_bus_tick;
    endproperty
    a_div_four: assert property (p_div_four) else $error("bus tick not one in four");

    property p_sync_path;
        @(posedge i_clock) disable iff (i_rst)
        i_ce |=> sync2_ff == $past(sync1_ff) && sync1_ff == $past(i_pin_in);
    endproperty
    a_sync_path: assert property (p_sync_path) else $error("pin synchroniser broken");

endmodule // rps_sequencer

/* inc/rps_pkg.sv */
// rps_pkg: constants, states and carriers for the reset pin and start-up sequencer
// assumes one clock; all cycle counts are in bus cycles (bus-tick enables) except OSC_DIV_LAST, which counts clock cycles
package rps_pkg;

    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] STARTUP_LONG_CYC = 12'hFE0;   // 4064
    localparam logic [CNT_W-1:0] STARTUP_SHORT_CYC = 12'h080;  // 128
    localparam logic [CNT_W-1:0] DRIVE_LOW_CYC = 12'h004;
    localparam logic [2:0] CLASSIFY_LIMIT = 3'h4;
    localparam logic [1:0] OSC_DIV_LAST = 2'h3;
    localparam logic [7:0] SYNTH_MULT_RESET = 8'h01;

    typedef enum logic [2:0] {
        ST_STARTUP = 3'h0,
        ST_RUN = 3'h1,
        ST_DRIVE = 3'h2,
        ST_CLASSIFY = 3'h3,
        ST_EXTERNAL = 3'h4,
        ST_HALT = 3'h5
    } rps_state_e;

    typedef struct packed {
        logic valid;
        logic internal;
    } rps_class_s;

    typedef struct packed {
        logic fail_clock_monitor;
        logic fail_watchdog;
    } rps_fail_s;

endpackage

/* src/rps_delay_counter.sv */
// rps_delay_counter: loadable down-counter of bus cycles
// assumes i_tick is a one-cycle bus-cycle enable from the caller
`timescale 1ns/1ps
module rps_delay_counter
    import rps_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_ce,
    // control
    input wire logic i_load,
    input wire logic [CNT_W-1:0] i_count,
    input wire logic i_tick,
    // status
    output logic o_done
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (i_load) begin
            nxt_cnt = i_count;
        end else if (i_tick && cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 12'h001;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else if (i_ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_done = (cnt_ff == '0) && !i_load;

endmodule // rps_delay_counter

/* tb/rps_supervisor_model.sv */
// rps_supervisor_model: reset switch or supervisor on the open-drain reset pin
// assumes a pull-up on the pin; the device only ever pulls it low
`timescale 1ns/1ps
module rps_supervisor_model #(
    parameter int SLOW_CYC = 40
) (
    // clock
    input wire logic i_clock,
    // commands from the bench
    input wire logic i_hold_low,
    input wire logic i_slow_rise,
    // device side of the pin
    input wire logic i_dev_oe,
    input wire logic i_dev_out,
    // resolved pin level
    output logic o_pin_level
);
    int slow_cnt = 0;

    // slow mode keeps the pin low after the device lets go, like a slow pull-up
    always @(posedge i_clock) begin
        if (i_dev_oe && i_slow_rise) begin
            slow_cnt <= SLOW_CYC;
        end else if (slow_cnt != 0) begin
            slow_cnt <= slow_cnt - 1;
        end
    end

    // released pin goes to the pull-up level
    assign o_pin_level = ((i_dev_oe && !i_dev_out) || i_hold_low || slow_cnt != 0) ? 1'b0 : 1'b1;
endmodule // rps_supervisor_model

/* tb/tb_top.sv */
// tb_top: self-checking bench for the reset pin and start-up sequencer
// assumes rps_sequencer with a supervisor model on the reset pin
`timescale 1ns/1ps
module tb_top
    import rps_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    rps_fail_s fail = '0;
    logic halt_enter = 1'b0;
    logic halt_exit = 1'b0;
    logic opt_present = 1'b0;
    logic opt_short = 1'b0;
    logic [7:0] opt_mult = 8'h00;
    logic sel_pll = 1'b0;
    logic pll_tick = 1'b0;
    logic hold_low = 1'b0;
    logic slow_rise = 1'b0;
    logic pin_level, pin_out, pin_oe, clk_sel_pll, bus_tick, sys_reset, run;
    rps_class_s cls;
    logic [7:0] synth_mult;
    int failures = 0;
    int n_tests = 0;

    always #5 clock = ~clock;

    rps_sequencer dut (.i_clock(clock), .i_rst(rst), .i_ce(ce), .i_pin_in(pin_level), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .i_fail(fail), .i_halt_enter(halt_enter), .i_halt_exit(halt_exit),
        .i_options_present(opt_present), .i_opt_short_startup(opt_short), .i_opt_synth_mult(opt_mult),
        .i_sw_select_pll(sel_pll), .i_pll_tick(pll_tick), .o_clk_sel_pll(clk_sel_pll), .o_bus_tick(bus_tick),
        .o_sys_reset(sys_reset), .o_run(run), .o_class(cls), .o_synth_mult(synth_mult));

    rps_supervisor_model u_sup (.i_clock(clock), .i_hold_low(hold_low), .i_slow_rise(slow_rise),
        .i_dev_oe(pin_oe), .i_dev_out(pin_out), .o_pin_level(pin_level));

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wait_run(input int lim, output int cyc);
        cyc = 0;
        while (run !== 1'b1 && cyc < lim) begin
            @(negedge clock);
            cyc++;
        end
    endtask

    // the pin is never driven high while enabled
    always @(negedge clock) begin
        if (pin_oe === 1'b1) begin
            chk("pin_out", 12'h000, 12'(pin_out));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_on(input logic pres, input logic shrt, input logic [7:0] mult,
                              input logic [7:0] exp_mult, input int exp_cyc);
        int cyc;
        opt_present = pres;
        opt_short = shrt;
        opt_mult = mult;
        rst = 1'b1;
        repeat (8) @(negedge clock);
        chk("run_in_reset", 12'h000, 12'(run));
        rst = 1'b0;
        chk("clk_sel_pll", 12'h000, 12'(clk_sel_pll));
        wait_run(exp_cyc * 4 + 40, cyc);
        chk("synth_mult", 12'(exp_mult), 12'(synth_mult));
        chk("startup_len", 12'h001, 12'(cyc >= exp_cyc * 4 - 4 && cyc <= exp_cyc * 4 + 16));
    endtask

    task automatic t_tick_osc();
        int n = 0;
        repeat (40) begin
            @(negedge clock);
            if (bus_tick === 1'b1) n++;
        end
        chk("osc_ticks", 12'h00A, 12'(n));
    endtask

    task automatic t_fail(input logic slow, input rps_fail_s f, input logic [1:0] exp_cls);
        int cyc;
        slow_rise = slow;
        fail = f;
        @(negedge clock);
        fail = '0;
        repeat (2) @(negedge clock);
        chk("pin_oe", 12'h001, 12'(pin_oe));
        chk("pin_level", 12'h000, 12'(pin_level));
        chk("run_in_fail", 12'h000, 12'(run));
        cyc = 0;
        while (pin_oe === 1'b1 && cyc < 100) begin
            @(negedge clock);
            cyc++;
        end
        chk("oe_released", 12'h000, 12'(pin_oe));
        wait_run(300, cyc);
        chk("class", 12'(exp_cls), 12'(cls));
        slow_rise = 1'b0;
    endtask

    task automatic t_ext_pin();
        int cyc;
        hold_low = 1'b1;
        repeat (2) @(negedge clock);
        chk("sys_reset_sync", 12'h000, 12'(sys_reset));
        repeat (3) @(negedge clock);
        chk("sys_reset_ext", 12'h001, 12'(sys_reset));
        chk("class_ext", 12'h002, 12'(cls));
        repeat (20) @(negedge clock);
        chk("run_held", 12'h000, 12'(run));
        hold_low = 1'b0;
        wait_run(20, cyc);
        chk("run_back", 12'h001, 12'(run));
    endtask

    task automatic t_freeze();
        ce = 1'b0;
        fail = rps_fail_s'(2'b11);
        repeat (4) @(negedge clock);
        fail = '0;
        ce = 1'b1;
        @(negedge clock);
        chk("run_frozen", 12'h001, 12'(run));
        chk("oe_frozen", 12'h000, 12'(pin_oe));
    endtask

    task automatic t_halt(input int exp_cyc);
        int cyc;
        halt_enter = 1'b1;
        @(negedge clock);
        halt_enter = 1'b0;
        repeat (2) @(negedge clock);
        chk("run_halt", 12'h000, 12'(run));
        halt_exit = 1'b1;
        @(negedge clock);
        halt_exit = 1'b0;
        wait_run(exp_cyc * 4 + 40, cyc);
        chk("halt_startup", 12'h001, 12'(cyc >= exp_cyc * 4 - 8 && cyc <= exp_cyc * 4 + 16));
    endtask

    task automatic t_pll();
        int n = 0;
        sel_pll = 1'b1;
        @(negedge clock);
        sel_pll = 1'b0;
        repeat (2) @(negedge clock);
        chk("clk_sel_pll_on", 12'h001, 12'(clk_sel_pll));
        pll_tick = 1'b1;
        repeat (3) @(negedge clock);
        repeat (16) begin
            @(negedge clock);
            if (bus_tick === 1'b1) n++;
        end
        chk("pll_ticks", 12'h010, 12'(n));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        t_power_on(1'b0, 1'b1, 8'hA5, 8'h01, 4064);
        t_tick_osc();
        t_fail(1'b0, rps_fail_s'(2'b01), 2'b11);
        t_fail(1'b1, rps_fail_s'(2'b10), 2'b10);
        t_ext_pin();
        t_freeze();
        t_halt(4064);
        t_pll();
        t_power_on(1'b1, 1'b1, 8'h5A, 8'h5A, 128);
        final_report();
    end

    initial begin
        #600000;
        failures++;
        final_report();
    end
endmodule // tb_top
